// ---- dv/scdi_src_model.sv ----
// Upstream sample source and modulator tick source.
// Assumes GAP cycles between ticks; stops only on a sample boundary.
`timescale 1ns/1ps
`default_nettype none
module scdi_src_model #(
  parameter int GAP = 2
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 run,
  input  wire scdi_pkg::scdi_pair_t smp,
  output logic                      in_valid,
  output scdi_pkg::scdi_pair_t      in_smp,
  output logic                      mod_tick,
  output int unsigned               n_smp
);
  int unsigned cyc_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_q <= 0;
      in_valid <= 1'b0;
      in_smp <= '0;
      mod_tick <= 1'b0;
      n_smp <= 0;
    end else begin
      in_valid <= run && cyc_q == 0;
      mod_tick <= (run || cyc_q != 0) && cyc_q % GAP == GAP - 1;
      if (run || cyc_q != 0) cyc_q <= (cyc_q + 1) % (128 * GAP);
      // Data is meaningless off the strobe, so it churns
      if (run && cyc_q == 0) begin
        in_smp <= smp;
        n_smp <= n_smp + 1;
      end else begin
        in_smp <= ~in_smp;
      end
    end
  end
endmodule : scdi_src_model
`default_nettype wire

// ---- dv/scdi_tb.sv ----
// Bench for scdi_top: register bus, sub compressor and main interpolator.
// Assumes the monitor and source model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "scdi_consts.svh"
module tb;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic [9:0]           avs_address = 10'h000;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = 32'h00000000;
  logic [31:0]          avs_readdata, q;
  logic                 avs_waitrequest, in_valid, mod_tick, main_valid, sub_valid;
  logic                 run = 1'b0;
  logic                 ce = 1'b1;
  scdi_pkg::scdi_pair_t in_smp, main_out;
  scdi_pkg::scdi_pair_t smp = '0;
  logic signed [23:0]   sub_out;
  int unsigned          n_smp;
  int                   fails = 0;
  int                   total_checks = 0;
  int                   n_tick = 0;
  int                   n_main = 0;
  logic [21:0] t_wl [4] = '{22'h100000, 22'h100000, 22'h1FFFFF, 22'h100000};
  logic [21:0] t_wr [4] = '{22'h080000, 22'h000000, 22'h100000, 22'h100000};
  logic [23:0] t_l  [4] = '{24'h100000, 24'h300000, 24'h7FFFFF, 24'h800000};
  logic [23:0] t_r  [4] = '{24'h200000, 24'h7FFFFF, 24'h7FFFFF, 24'h800000};
  logic [23:0] t_e  [4] = '{24'h200000, 24'h300000, 24'h7FFFFF, 24'h800000};
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (mod_tick === 1'b1) n_tick <= n_tick + 1;
    if (main_valid === 1'b1) n_main <= n_main + 1;
  end
  scdi_top #(.CIC_N(5)) uut (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_smp(in_smp), .mod_tick(mod_tick), .main_out(main_out), .main_valid(main_valid),
    .sub_out(sub_out), .sub_valid(sub_valid));
  scdi_src_model #(.GAP(2)) src (.mclk(mclk), .rst(rst), .run(run), .smp(smp),
    .in_valid(in_valid), .in_smp(in_smp), .mod_tick(mod_tick), .n_smp(n_smp));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at an edge
  // Only the watchdog ends a wait that never gets its answer
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wait_smp(input int unsigned n);
    do @(posedge mclk); while (n_smp < n);
  endtask : wait_smp
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) if (i != 1) begin
      bus(1'b0, 10'(4 * i), 32'h0);
      chk("reset word", 32'h0, q);
      bus(1'b1, 10'(4 * i), 32'hFFFFFFFF);
      bus(1'b0, 10'(4 * i), 32'h0);
      chk("word width", 32'h003FFFFF, q);
      bus(1'b1, 10'(4 * i), 32'h0);
    end
    // Status word ignores writes
    bus(1'b1, 10'h004, 32'hFFFFFFFF);
    bus(1'b0, 10'h004, 32'h0);
    chk("status read only", 32'h0, q);
    for (int k = 3; k >= 0; k--) begin
      bus(1'b1, 10'h000, 32'(k << 4));
      bus(1'b0, 10'h000, 32'h0);
      chk("curve select", 32'(k << 4), q);
    end
    bus(1'b1, 10'h1E4, 32'hFFFFFFFF);
    bus(1'b0, 10'h1E4, 32'h0);
    chk("unmapped word", 32'h0, q);
    bus(1'b0, 10'h009, 32'h0);
    chk("unaligned word", 32'h0, q);
    for (int i = 0; i < `SCDI_LUT_ENTRIES; i++) bus(1'b1, 10'(4 * (16 + i)), 32'h00100000);
    // Frozen enable must stall the answer, not drop it
    ce <= 1'b0;
    fork
      bus(1'b0, 10'(4 * `SCDI_IDX_LUT_LAST), 32'h0);
      begin
        repeat (6) @(posedge mclk);
        ce <= 1'b1;
      end
    join
    chk("stalled read", 32'h00100000, q);
    // No delay trim here: main trails sub by the line
    smp <= '{24'h123400, 24'hFC0000};
    run <= 1'b1;
    wait_smp(20);
    chk("main early", 32'h0, {8'h00, main_out.l});
    wait_smp(45);
    chk("main dc l", 32'h00123400, {8'h00, main_out.l});
    chk("main dc r", 32'h00FC0000, {8'h00, main_out.r});
    // Shelf has unity gain at DC, so the level holds within rounding
    bus(1'b1, 10'h000, 32'h00000010);
    wait_smp(n_smp + 40);
    chk("deemph dc l", 32'h1, 32'(main_out.l inside {[24'sh1233C0:24'sh123440]}));
    // Detector filter kept off the gain path
    bus(1'b1, 10'(4 * `SCDI_IDX_BQ_B0), 32'h001FFFFF);
    // Weighted sum, clipped at both ends
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 10'(4 * `SCDI_IDX_WL), 32'(t_wl[i]));
      bus(1'b1, 10'(4 * `SCDI_IDX_WR), 32'(t_wr[i]));
      smp <= '{t_l[i], t_r[i]};
      wait_smp(n_smp + 2);
      do @(posedge mclk); while (sub_valid !== 1'b1);
      chk("sub output", {8'h00, t_e[i]}, {8'h00, sub_out});
    end
    run <= 1'b0;
    repeat (600) @(posedge mclk);
    chk("main per tick", 32'(n_tick), 32'(n_main));
    chk("ticks per sample", 32'(128 * n_smp), 32'(n_tick));
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// ---- dv/scdi_top_monitor.sv ----
// Port-level timing checker for scdi_top.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module scdi_top_monitor (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic                 in_valid,
  input wire logic                 mod_tick,
  input wire scdi_pkg::scdi_pair_t main_out,
  input wire logic                 main_valid,
  input wire logic signed [23:0]   sub_out,
  input wire logic                 sub_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic req;
  assign req = avs_read | avs_write;
  ////////////////////////////////////////////////////////////////
  property p_wait_one;
    req && ce && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait cycle");
  property p_wait_once;
    req && !avs_waitrequest |=> avs_waitrequest || !req;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("answer held past one cycle");
  property p_wait_idle;
    !req |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait raised with no request");
  property p_rd_hold;
    !(avs_read && avs_waitrequest && ce) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  ////////////////////////////////////////////////////////////////
  property p_sub_go;
    in_valid && ce |=> sub_valid;
  endproperty
  a_sub_go: assert property (p_sub_go) else $error("sub output late");
  property p_sub_why;
    sub_valid |-> $past(in_valid);
  endproperty
  a_sub_why: assert property (p_sub_why) else $error("sub output without a sample");
  property p_sub_hold;
    !sub_valid |-> $stable(sub_out);
  endproperty
  a_sub_hold: assert property (p_sub_hold) else $error("sub output moved between samples");
  ////////////////////////////////////////////////////////////////
  property p_main_go;
    mod_tick && ce |=> main_valid;
  endproperty
  a_main_go: assert property (p_main_go) else $error("main output missed a tick");
  property p_main_why;
    main_valid |-> $past(mod_tick);
  endproperty
  a_main_why: assert property (p_main_why) else $error("main output without a tick");
  property p_main_hold;
    !main_valid |-> $stable(main_out);
  endproperty
  a_main_hold: assert property (p_main_hold) else $error("main output moved between ticks");
endmodule : scdi_top_monitor
bind scdi_top scdi_top_monitor u_mon (.mclk, .rst, .ce, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .in_valid, .mod_tick, .main_out, .main_valid, .sub_out, .sub_valid);
`default_nettype wire

// ---- logic/scdi_consts.svh ----
// Constants for the sub compressor, de-emphasis and interpolation block.
// Assumes inclusion by bare name from logic/ and one 250 MHz clock domain.
`ifndef SCDI_CONSTS_SVH
`define SCDI_CONSTS_SVH

// Register word indexes; byte address is four times these
`define SCDI_IDX_CTRL1      6'h00
`define SCDI_IDX_STATUS     6'h01
`define SCDI_IDX_WL         6'h02
`define SCDI_IDX_WR         6'h03
`define SCDI_IDX_REINJ_L    6'h04
`define SCDI_IDX_REINJ_R    6'h05
`define SCDI_IDX_BQ_B0      6'h06
`define SCDI_IDX_BQ_B1      6'h07
`define SCDI_IDX_BQ_B2      6'h08
`define SCDI_IDX_BQ_A1      6'h09
`define SCDI_IDX_BQ_A2      6'h0A
`define SCDI_IDX_TCONST     6'h0B
`define SCDI_IDX_HOLD       6'h0C
`define SCDI_IDX_RELEASE    6'h0D
`define SCDI_IDX_LUT0       6'h10
`define SCDI_IDX_LUT_LAST   6'h30
`define SCDI_LUT_ENTRIES    33
`define SCDI_NUM_WORDS      64

// Control register 1 fields
`define SCDI_DEEMPH_LSB     4
`define SCDI_DEEMPH_MSB     5
`define SCDI_CTRL1_RST      22'h000000

// Coefficient format 2.20
`define SCDI_CW             22
`define SCDI_FRAC           20
`define SCDI_UNITY          22'h100000

// De-emphasis: pole 50 us, zero 15 us; bilinear sets per rate
`define SCDI_DE_POLE_US     50
`define SCDI_DE_ZERO_US     15
`define SCDI_DE48_B0        22'h06BB26
`define SCDI_DE48_B1        22'h3EC946
`define SCDI_DE48_A1        22'h358468
`define SCDI_DE441_B0       22'h06DEC5
`define SCDI_DE441_B1       22'h3F0B77
`define SCDI_DE441_A1       22'h35EA41
`define SCDI_DE32_B0        22'h077778
`define SCDI_DE32_B1        22'h002702
`define SCDI_DE32_A1        22'h379E7A

// Interpolation: 128:1, log2 = 7; extra input-rate delay to reach 24.185 periods
`define SCDI_OSR_LOG2       7
`define SCDI_OSR            128
`define SCDI_MAIN_DLY       22
`define SCDI_LUT_IDX_OFS    8

`endif

// ---- logic/scdi_pkg.sv ----
// Types for the sub compressor, de-emphasis and interpolation block.
// Assumes the constants header is present beside it.
package scdi_pkg;

  typedef struct packed {
    logic signed [23:0] l;
    logic signed [23:0] r;
  } scdi_pair_t;

  typedef enum logic [1:0] {
    SCDI_DE_OFF  = 2'h0,
    SCDI_DE_48K  = 2'h1,
    SCDI_DE_441K = 2'h2,
    SCDI_DE_32K  = 2'h3
  } scdi_deemph_t;

  typedef enum logic {
    SCDI_BUS_IDLE = 1'b0,
    SCDI_BUS_ACK  = 1'b1
  } scdi_bus_st_t;

endpackage : scdi_pkg

// ---- logic/scdi_top.sv ----
// Sub compressor/limiter, de-emphasis, sub reinjection and 128:1 main interpolator.
// Assumes one sample per in_valid and 128 mod_tick pulses per sample from the modulator.
//
// Functional notes
// - The sub compressor input is left times sub_left_weight plus right times sub_right_weight.
// - The sub detector runs through a programmable biquad that the gain path does not see.
// - The sub gain multiplier acts on the undelayed weighted sum, with no look-ahead.
// - De-emphasis is a first-order shelf modelling a 50 us pole and a 15 us zero.
// - De-emphasis is its own stage, separate from any channel biquad.
// - Three fixed coefficient sets serve 32 kHz, 44.1 kHz and 48 kHz.
// - The curve is chosen by bits 5:4 of control register 1, written by the controller.
// - Two 2.20 reinjection coefficients from parameter memory scale the sub into the mains.
// - Left and right are interpolated 128:1 before the modulator.
// - The main path delay is about 24.185 input sample periods.
// - The sub output bypasses interpolation and leaves at the input rate.
// - Sub gain comes from a 33-entry 2.20 table, 3 dB per index step, interpolated.
// - The detector uses rms time constant, hold time and release rate from parameter memory.
`timescale 1ns/1ps
`default_nettype none
`include "scdi_consts.svh"

module scdi_top #(
  parameter int CIC_N = 5
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [9:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 in_valid,
  input  wire scdi_pkg::scdi_pair_t in_smp,
  input  wire logic                 mod_tick,
  output scdi_pkg::scdi_pair_t      main_out,
  output logic                      main_valid,
  output logic signed [23:0]        sub_out,
  output logic                      sub_valid
);

  localparam int CW = 24 + CIC_N * `SCDI_OSR_LOG2;
  localparam int SH = (CIC_N - 1) * `SCDI_OSR_LOG2;

  if (CIC_N < 4 || CIC_N > 6) begin : g_chk
    $error("CIC_N must lie in 4..6 for the stop-band target");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers
  function automatic logic signed [47:0] mulx(input logic signed [23:0] x,
                                              input logic signed [21:0] c);
    logic signed [47:0] p;
    p    = 48'(x) * 48'(c);
    mulx = p >>> `SCDI_FRAC;
  endfunction : mulx

  // Clip instead of wrap
  function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
    if (v > 48'sh0000007FFFFF) sat24 = 24'sh7FFFFF;
    else if (v < -48'sh000000800000) sat24 = -24'sh800000;
    else sat24 = v[23:0];
  endfunction : sat24

  function automatic logic signed [21:0] de_coef(input scdi_pkg::scdi_deemph_t s,
                                                 input logic [1:0] k);
    logic [65:0] t;
    unique case (s)
      scdi_pkg::SCDI_DE_48K:  t = {`SCDI_DE48_B0, `SCDI_DE48_B1, `SCDI_DE48_A1};
      scdi_pkg::SCDI_DE_441K: t = {`SCDI_DE441_B0, `SCDI_DE441_B1, `SCDI_DE441_A1};
      scdi_pkg::SCDI_DE_32K:  t = {`SCDI_DE32_B0, `SCDI_DE32_B1, `SCDI_DE32_A1};
      default:                t = {`SCDI_UNITY, 22'h000000, 22'h000000};
    endcase
    de_coef = t[65 - 22 * k -: 22];
  endfunction : de_coef

  ////////////////////////////////////////////////////////////////////////////
  // Register file over Avalon-MM
  logic [21:0]            prm_q [`SCDI_NUM_WORDS];
  logic [21:0]            prm_d [`SCDI_NUM_WORDS];
  scdi_pkg::scdi_bus_st_t bus_q, bus_d;
  logic [31:0]            rdata_q, rdata_d;
  logic signed [23:0]     env_q, env_d;
  logic [5:0]             widx;
  logic                   wmapped;

  assign widx    = avs_address[7:2];
  assign wmapped = (avs_address[9:8] == 2'h0) && (avs_address[1:0] == 2'h0);
  // One wait cycle; a frozen clock enable stalls the master
  assign avs_waitrequest = (avs_read | avs_write) & ~(ce & (bus_q == scdi_pkg::SCDI_BUS_ACK));
  assign avs_readdata    = rdata_q;

  always_comb begin
    prm_d   = prm_q;
    bus_d   = bus_q;
    rdata_d = rdata_q;
    unique case (bus_q)
      scdi_pkg::SCDI_BUS_IDLE: begin
        if (avs_read | avs_write) begin
          bus_d = scdi_pkg::SCDI_BUS_ACK;
          // Only a read moves read data; it stands across writes
          if (avs_read) rdata_d = 32'h00000000;
          if (avs_read && wmapped) begin
            if (widx == `SCDI_IDX_STATUS) rdata_d = {8'h00, env_q};
            else rdata_d = {10'h000, prm_q[widx]};
          end
        end
      end
      scdi_pkg::SCDI_BUS_ACK: begin
        bus_d = scdi_pkg::SCDI_BUS_IDLE;
        if (avs_write && wmapped && widx != `SCDI_IDX_STATUS) prm_d[widx] = avs_writedata[21:0];
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_q   <= scdi_pkg::SCDI_BUS_IDLE;
      rdata_q <= 32'h00000000;
      for (int i = 0; i < `SCDI_NUM_WORDS; i++) prm_q[i] <= 22'h000000;
    end else if (ce) begin
      bus_q   <= bus_d;
      rdata_q <= rdata_d;
      prm_q   <= prm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sub compressor and de-emphasis, one sample per in_valid
  logic signed [23:0]     bx_q [2];
  logic signed [23:0]     bx_d [2];
  logic signed [23:0]     by_q [2];
  logic signed [23:0]     by_d [2];
  logic signed [23:0]     ms_q, ms_d;
  logic [21:0]            hold_q, hold_d;
  logic signed [23:0]     dx_q [2];
  logic signed [23:0]     dx_d [2];
  logic signed [23:0]     dy_q [2];
  logic signed [23:0]     dy_d [2];
  scdi_pkg::scdi_deemph_t sel_q, sel_d;
  logic signed [23:0]     sub_q, sub_d;
  logic                   subv_q, subv_d;
  logic signed [23:0]     dly_q [2][`SCDI_MAIN_DLY];
  logic signed [23:0]     dly_d [2][`SCDI_MAIN_DLY];
  logic signed [23:0]     wsum, det, pw, chx, chy;
  logic signed [21:0]     gain, g0, g1;
  logic [4:0]             lidx;
  logic [3:0]             lfrac;
  logic [23:0]            norm;

  always_comb begin
    bx_d   = bx_q;
    by_d   = by_q;
    ms_d   = ms_q;
    env_d  = env_q;
    hold_d = hold_q;
    dx_d   = dx_q;
    dy_d   = dy_q;
    sel_d  = sel_q;
    sub_d  = sub_q;
    dly_d  = dly_q;
    subv_d = 1'b0;
    chx    = 24'sh000000;
    chy    = 24'sh000000;
    wsum = sat24(mulx(in_smp.l, prm_q[`SCDI_IDX_WL]) + mulx(in_smp.r, prm_q[`SCDI_IDX_WR]));
    det = sat24(mulx(wsum, prm_q[`SCDI_IDX_BQ_B0]) + mulx(bx_q[0], prm_q[`SCDI_IDX_BQ_B1])
              + mulx(bx_q[1], prm_q[`SCDI_IDX_BQ_B2]) - mulx(by_q[0], prm_q[`SCDI_IDX_BQ_A1])
              - mulx(by_q[1], prm_q[`SCDI_IDX_BQ_A2]));
    pw  = sat24((48'(det) * 48'(det)) >>> 23);
    // Log index: each power octave is 3 dB
    lidx  = 5'h00;
    norm  = env_q;
    for (int b = 0; b < 24; b++) begin
      if (env_q[b]) begin
        lidx = 5'(b + `SCDI_LUT_IDX_OFS);
        norm = env_q << (23 - b);
      end
    end
    lfrac = norm[22:19];
    g0    = prm_q[`SCDI_IDX_LUT0 + 6'(lidx)];
    g1    = prm_q[`SCDI_IDX_LUT0 + 6'(lidx) + 6'h01];
    gain  = 22'(g0 + 22'((48'(g1 - g0) * 48'(lfrac)) >>> 4));
    if (in_valid) begin
      bx_d[0] = wsum;
      bx_d[1] = bx_q[0];
      by_d[0] = det;
      by_d[1] = by_q[0];
      ms_d = sat24(48'(ms_q) + mulx(sat24(48'(pw) - 48'(ms_q)), prm_q[`SCDI_IDX_TCONST]));
      if (ms_d >= env_q) begin
        env_d  = ms_d;
        hold_d = prm_q[`SCDI_IDX_HOLD];
      end else if (hold_q != 22'h000000) begin
        hold_d = hold_q - 22'h000001;
      end else if (48'(env_q) > 48'(prm_q[`SCDI_IDX_RELEASE])) begin
        env_d = 24'(48'(env_q) - 48'(prm_q[`SCDI_IDX_RELEASE]));
      end else begin
        env_d = 24'sh000000;
      end
      sub_d  = sat24(mulx(wsum, gain));
      subv_d = 1'b1;
      for (int c = 0; c < 2; c++) begin
        chx = (c == 0) ? in_smp.l : in_smp.r;
        if (sel_q == scdi_pkg::SCDI_DE_OFF) chy = chx;
        else chy = sat24(mulx(chx, de_coef(sel_q, 2'h0)) + mulx(dx_q[c], de_coef(sel_q, 2'h1))
                       - mulx(dy_q[c], de_coef(sel_q, 2'h2)));
        dx_d[c] = chx;
        dy_d[c] = chy;
        dly_d[c][0] = sat24(48'(chy) + mulx(sub_d, prm_q[(c == 0) ? `SCDI_IDX_REINJ_L : `SCDI_IDX_REINJ_R]));
        for (int k = 1; k < `SCDI_MAIN_DLY; k++) dly_d[c][k] = dly_q[c][k - 1];
      end
      sel_d = scdi_pkg::scdi_deemph_t'(prm_q[`SCDI_IDX_CTRL1][`SCDI_DEEMPH_MSB:`SCDI_DEEMPH_LSB]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ms_q   <= 24'sh000000;
      env_q  <= 24'sh000000;
      hold_q <= 22'h000000;
      sel_q  <= scdi_pkg::SCDI_DE_OFF;
      sub_q  <= 24'sh000000;
      subv_q <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        bx_q[c] <= 24'sh000000;
        by_q[c] <= 24'sh000000;
        dx_q[c] <= 24'sh000000;
        dy_q[c] <= 24'sh000000;
        for (int k = 0; k < `SCDI_MAIN_DLY; k++) dly_q[c][k] <= 24'sh000000;
      end
    end else if (ce) begin
      bx_q   <= bx_d;
      by_q   <= by_d;
      ms_q   <= ms_d;
      env_q  <= env_d;
      hold_q <= hold_d;
      dx_q   <= dx_d;
      dy_q   <= dy_d;
      sel_q  <= sel_d;
      sub_q  <= sub_d;
      subv_q <= subv_d;
      dly_q  <= dly_d;
    end
  end

  // Sub leaves at the input rate, no interpolation
  assign sub_out   = sub_q;
  assign sub_valid = subv_q;

  ////////////////////////////////////////////////////////////////////////////
  // 128:1 CIC interpolator; combs at input rate, integrators on mod_tick
  logic signed [CW-1:0] cd_q [2][CIC_N];
  logic signed [CW-1:0] cd_d [2][CIC_N];
  logic signed [CW-1:0] it_q [2][CIC_N];
  logic signed [CW-1:0] it_d [2][CIC_N];
  logic signed [CW-1:0] cv_q [2];
  logic signed [CW-1:0] cv_d [2];
  logic                 first_q, first_d;
  scdi_pkg::scdi_pair_t mo_q, mo_d;
  logic                 mv_q, mv_d;
  logic signed [CW-1:0] acc;
  logic signed [CW-1:0] sh;

  always_comb begin
    cd_d    = cd_q;
    it_d    = it_q;
    cv_d    = cv_q;
    first_d = first_q;
    mo_d    = mo_q;
    mv_d    = 1'b0;
    acc     = '0;
    sh      = '0;
    for (int c = 0; c < 2; c++) begin
      if (in_valid) begin
        // Comb chain on the delayed main sample
        acc = CW'(dly_q[c][`SCDI_MAIN_DLY - 1]);
        for (int k = 0; k < CIC_N; k++) begin
          cd_d[c][k] = acc;
          acc        = acc - cd_q[c][k];
        end
        cv_d[c] = acc;
      end
      if (mod_tick) begin
        it_d[c][0] = it_q[c][0] + (first_q ? cv_q[c] : '0);
        for (int k = 1; k < CIC_N; k++) it_d[c][k] = it_q[c][k] + it_q[c][k - 1];
        sh = it_q[c][CIC_N - 1] >>> SH;
        if (c == 0) mo_d.l = sat24(48'(sh));
        else mo_d.r = sat24(48'(sh));
        mv_d = 1'b1;
      end
    end
    if (in_valid) first_d = 1'b1;
    else if (mod_tick) first_d = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      first_q <= 1'b0;
      mo_q    <= '0;
      mv_q    <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        cv_q[c] <= '0;
        for (int k = 0; k < CIC_N; k++) begin
          cd_q[c][k] <= '0;
          it_q[c][k] <= '0;
        end
      end
    end else if (ce) begin
      first_q <= first_d;
      mo_q    <= mo_d;
      mv_q    <= mv_d;
      cv_q    <= cv_d;
      cd_q    <= cd_d;
      it_q    <= it_d;
    end
  end

  assign main_out   = mo_q;
  assign main_valid = mv_q;

endmodule : scdi_top
`default_nettype wire
